// File: logic/otp_programmer.sv
`include "otp_prog_params.svh"
module otp_programmer #(
    parameter int          ADDR_W       = `ADDR_BITS,
    parameter int unsigned PULSE_CYC    = `PULSE_CYCLES,
    parameter int unsigned SETUP_CYC    = `SETUP_CYCLES,
    parameter int unsigned READ_CYC     = `READ_CYCLES,
    parameter int unsigned MAX_REPULSE  = `MAX_REPULSES,
    parameter logic [ADDR_W-1:0] LAST_ADDR = '1
) (
    input  wire logic                core_clk,
    input  wire logic                arst_n,
    input  wire logic                startProgram,
    input  wire logic                startIdRead,
    output logic [ADDR_W-1:0]        srcAddr,
    input  wire otp_prog_pkg::byte_t srcData,
    output logic                     busy,
    output logic                     done,
    output logic                     passed,
    output logic                     failed,
    output otp_prog_pkg::byte_t      makerCode,
    output otp_prog_pkg::byte_t      deviceCode,
    output logic [ADDR_W-1:0]        memAddr,
    output logic                     chipEnable_n,
    output logic                     outputEnable_n,
    output logic                     program_strobe_low,
    output otp_prog_pkg::byte_t      dataOut,
    output logic                     dataOe,
    input  wire otp_prog_pkg::byte_t dataIn,
    output logic                     mainSupplyHigh,
    output logic                     progSupplyHigh,
    output logic                     progSupplyOn,
    output logic                     identification_high_voltage
);
    import otp_prog_pkg::*;

    prog_state_t        state_r, state_nxt;
    logic [31:0]        timer_r, timer_nxt;
    logic [3:0]         tries_r, tries_nxt;
    logic [ADDR_W-1:0]  addr_r, addr_nxt;
    logic               done_r, done_nxt, pass_r, pass_nxt, fail_r, fail_nxt;
    logic               finalBad_r, finalBad_nxt, idMode_r, idMode_nxt;
    byte_t              maker_r, maker_nxt, device_r, device_nxt;
    byte_t              wdata_r, wdata_nxt;
    logic               timerDone, lastAddr, match;

    assign timerDone = (timer_r == 32'h0000_0000);
    assign lastAddr  = (addr_r == LAST_ADDR);
    assign match     = (dataIn == srcData);

    always_comb begin
        state_nxt    = state_r;
        timer_nxt    = timerDone ? timer_r : timer_r - 32'h0000_0001;
        tries_nxt    = tries_r;
        addr_nxt     = addr_r;
        done_nxt     = done_r;
        pass_nxt     = pass_r;
        fail_nxt     = fail_r;
        finalBad_nxt = finalBad_r;
        idMode_nxt   = idMode_r;
        maker_nxt    = maker_r;
        device_nxt   = device_r;
        // Registered write data lags the address by one cycle, well inside the setup wait
        wdata_nxt    = srcData;
        case (state_r)
            ST_IDLE: begin
                if (startProgram) begin
                    addr_nxt     = '0; // R2
                    done_nxt     = 1'b0;
                    pass_nxt     = 1'b0;
                    fail_nxt     = 1'b0;
                    finalBad_nxt = 1'b0;
                    idMode_nxt   = 1'b0;
                    timer_nxt    = SETUP_CYC;
                    state_nxt    = ST_PWR_MAIN;
                end else if (startIdRead) begin
                    done_nxt   = 1'b0;
                    idMode_nxt = 1'b1;
                    addr_nxt   = '0;
                    timer_nxt  = SETUP_CYC;
                    state_nxt  = ST_ID_ENTER;
                end
            end
            // Main supply settles before the program supply is raised
            ST_PWR_MAIN: if (timerDone) begin // R3 R12
                timer_nxt = SETUP_CYC;
                state_nxt = ST_PWR_PROG;
            end
            ST_PWR_PROG: if (timerDone) begin // R3
                timer_nxt = SETUP_CYC;
                state_nxt = ST_P1_SETUP;
            end
            ST_P1_SETUP: if (timerDone) begin
                timer_nxt = PULSE_CYC;
                state_nxt = ST_P1_PULSE;
            end
            ST_P1_PULSE: if (timerDone) begin // R1 R4
                timer_nxt = SETUP_CYC;
                state_nxt = ST_P1_HOLD;
            end
            ST_P1_HOLD: if (timerDone) begin
                timer_nxt = SETUP_CYC;
                if (lastAddr) begin
                    addr_nxt  = '0;
                    tries_nxt = '0;
                    timer_nxt = READ_CYC;
                    state_nxt = ST_V_READ;
                end else begin
                    addr_nxt  = addr_r + 1'b1; // R4
                    state_nxt = ST_P1_SETUP;
                end
            end
            ST_V_READ: if (timerDone) begin // R5
                if (match) begin
                    tries_nxt = '0;
                    if (lastAddr) begin // R7
                        timer_nxt = SETUP_CYC;
                        state_nxt = ST_LOWER_PROG;
                    end else begin
                        addr_nxt  = addr_r + 1'b1; // R7
                        timer_nxt = READ_CYC;
                    end
                end else if (tries_r == 4'(MAX_REPULSE)) begin
                    fail_nxt  = 1'b1; // R6
                    timer_nxt = SETUP_CYC;
                    state_nxt = ST_LOWER_PROG;
                end else begin
                    tries_nxt = tries_r + 4'h1; // R5
                    timer_nxt = SETUP_CYC;
                    state_nxt = ST_V_SETUP;
                end
            end
            ST_V_SETUP: if (timerDone) begin
                timer_nxt = PULSE_CYC;
                state_nxt = ST_V_PULSE;
            end
            ST_V_PULSE: if (timerDone) begin // R1
                timer_nxt = SETUP_CYC;
                state_nxt = ST_V_HOLD;
            end
            ST_V_HOLD: if (timerDone) begin
                timer_nxt = READ_CYC;
                state_nxt = ST_V_READ;
            end
            ST_LOWER_PROG: if (timerDone) begin // R8
                timer_nxt = SETUP_CYC;
                state_nxt = ST_LOWER_MAIN;
            end
            ST_LOWER_MAIN: if (timerDone) begin // R8
                addr_nxt  = '0;
                timer_nxt = READ_CYC;
                // A failed verify skips the final compare; the part is already bad
                state_nxt = fail_r ? ST_PWR_OFF : ST_F_READ;
            end
            ST_F_READ: if (timerDone) begin // R9
                if (!match)
                    finalBad_nxt = 1'b1;
                timer_nxt = READ_CYC;
                if (lastAddr) begin
                    timer_nxt = SETUP_CYC;
                    state_nxt = ST_PWR_OFF;
                end else begin
                    addr_nxt = addr_r + 1'b1;
                end
            end
            ST_PWR_OFF: if (timerDone) begin // R12
                done_nxt  = 1'b1;
                pass_nxt  = !fail_r && !finalBad_r; // R9
                fail_nxt  = fail_r || finalBad_r;
                state_nxt = ST_IDLE;
            end
            ST_ID_ENTER: if (timerDone) begin // R10
                timer_nxt = READ_CYC;
                state_nxt = ST_ID_READ;
            end
            ST_ID_READ: if (timerDone) begin // R11
                if (addr_r[0] == `ID_MAKER_SEL) begin
                    maker_nxt = dataIn;
                    addr_nxt  = {{(ADDR_W-1){1'b0}}, `ID_DEVICE_SEL};
                    timer_nxt = READ_CYC;
                end else begin
                    device_nxt = dataIn;
                    addr_nxt   = '0;
                    idMode_nxt = 1'b0;
                    done_nxt   = 1'b1;
                    state_nxt  = ST_IDLE;
                end
            end
            default: state_nxt = ST_IDLE;
        endcase
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            state_r    <= ST_IDLE;
            timer_r    <= 32'h0000_0000;
            tries_r    <= 4'h0;
            addr_r     <= '0;
            done_r     <= 1'b0;
            pass_r     <= 1'b0;
            fail_r     <= 1'b0;
            finalBad_r <= 1'b0;
            idMode_r   <= 1'b0;
            maker_r    <= 8'h00;
            device_r   <= 8'h00;
            wdata_r    <= 8'h00;
        end else begin
            state_r    <= state_nxt;
            timer_r    <= timer_nxt;
            tries_r    <= tries_nxt;
            addr_r     <= addr_nxt;
            done_r     <= done_nxt;
            pass_r     <= pass_nxt;
            fail_r     <= fail_nxt;
            finalBad_r <= finalBad_nxt;
            idMode_r   <= idMode_nxt;
            maker_r    <= maker_nxt;
            device_r   <= device_nxt;
            wdata_r    <= wdata_nxt;
        end
    end

    logic inPulse, inWrite, inRead, inHigh, mainOn;
    assign inPulse = (state_r == ST_P1_PULSE) || (state_r == ST_V_PULSE);
    assign inWrite = inPulse || (state_r == ST_P1_SETUP) || (state_r == ST_P1_HOLD)
                   || (state_r == ST_V_SETUP) || (state_r == ST_V_HOLD);
    assign inRead  = (state_r == ST_V_READ) || (state_r == ST_F_READ)
                   || (state_r == ST_ID_READ);
    assign inHigh  = (state_r != ST_IDLE) && (state_r != ST_LOWER_MAIN)
                   && (state_r != ST_F_READ) && (state_r != ST_PWR_OFF)
                   && !idMode_r;

    assign srcAddr                     = addr_r;
    assign memAddr                     = addr_r;
    assign busy                        = (state_r != ST_IDLE);
    assign done                        = done_r;
    assign passed                      = pass_r;
    assign failed                      = fail_r;
    assign makerCode                   = maker_r;
    assign deviceCode                  = device_r;
    assign chipEnable_n                = !(inWrite || inRead); // R13
    assign outputEnable_n              = !inRead;              // R13
    assign program_strobe_low          = !inPulse;             // R1 R13
    assign dataOut                     = wdata_r;
    assign dataOe                      = inWrite;              // R13
    assign mainSupplyHigh              = inHigh;               // R3 R8
    assign progSupplyHigh              = inHigh && (state_r != ST_PWR_MAIN)
                                       && (state_r != ST_LOWER_PROG); // R12
    assign mainOn                      = busy;
    assign progSupplyOn                = mainOn && (state_r != ST_PWR_OFF); // R12
    assign identification_high_voltage = idMode_r;             // R10

    int unsigned pulseLen;
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n)
            pulseLen <= 0;
        else
            pulseLen <= inPulse ? pulseLen + 1 : 0;
    end

    a_pulse_width: assert property (@(posedge core_clk) disable iff (!arst_n) // R1
        $rose(program_strobe_low) |-> pulseLen == PULSE_CYC + 1)
        else $error("program pulse width wrong");
    a_prog_after_main: assert property (@(posedge core_clk) disable iff (!arst_n) // R12
        progSupplyHigh |-> mainSupplyHigh)
        else $error("program supply high without main supply");
    a_retry_limit: assert property (@(posedge core_clk) disable iff (!arst_n) // R5
        tries_r <= 4'(MAX_REPULSE))
        else $error("too many re-pulses");
    a_pulse_hv: assert property (@(posedge core_clk) disable iff (!arst_n) // R3
        inPulse |-> mainSupplyHigh && progSupplyHigh)
        else $error("pulse without raised supplies");
    a_pulse_bus: assert property (@(posedge core_clk) disable iff (!arst_n) // R13
        inPulse |-> !chipEnable_n && outputEnable_n && dataOe)
        else $error("bad pin state during pulse");
    a_final_low: assert property (@(posedge core_clk) disable iff (!arst_n) // R8
        state_r == ST_F_READ |-> !mainSupplyHigh && !progSupplyHigh)
        else $error("final read at raised supplies");
    a_fail_report: assert property (@(posedge core_clk) disable iff (!arst_n) // R6
        (state_r == ST_V_READ && timerDone && !match && tries_r == 4'(MAX_REPULSE))
        |=> fail_r)
        else $error("failure not reported");
    a_start_addr: assert property (@(posedge core_clk) disable iff (!arst_n) // R2
        (state_r == ST_IDLE && startProgram) |=> addr_r == '0)
        else $error("run not started at first address");
    a_main_first: assert property (@(posedge core_clk) disable iff (!arst_n) // R12
        $rose(progSupplyHigh) |-> $past(mainSupplyHigh))
        else $error("program supply raised before main supply");
    a_main_last: assert property (@(posedge core_clk) disable iff (!arst_n) // R12
        $fell(mainSupplyHigh) |-> !$past(progSupplyHigh))
        else $error("main supply lowered before program supply");
endmodule // otp_programmer

// File: logic/otp_prog_params.svh
`ifndef OTP_PROG_PARAMS_SVH
`define OTP_PROG_PARAMS_SVH
// Functional notes
// [R1] Program strobe pulse lasts 100 us, within plus or minus five percent.
// [R2] A run starts with the address on the first location.
// [R3] Raise main supply to 6.5 V and program supply to 13.0 V first.
// [R4] First pass: one pulse per address, no verification.
// [R5] Second pass: verify, re-pulse while mismatched, at most 10, verify after each.
// [R6] Still failing after the tenth re-pulse: report the whole device failed.
// [R7] A verified byte advances the address until all are checked.
// [R8] After verify pass lower program supply and main supply to 5.0 V.
// [R9] Read every byte again at low supplies; the compare decides pass or fail.
// [R10] Identification mode needs 11.5 V to 12.5 V on address line nine.
// [R11] Identification: bit zero low gives maker code, high gives device code.
// [R12] Main supply on no later, and off no earlier, than program supply.
// [R13] Pulse with chip select low, outputs off; verify with strobe high, output enabled.
`define CLK_PERIOD_NS      8
`define PULSE_TIME_NS      100000
`define PULSE_CYCLES       (`PULSE_TIME_NS / `CLK_PERIOD_NS)
`define SETUP_TIME_NS      2000
`define SETUP_CYCLES       ((`SETUP_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define READ_TIME_NS       150
`define READ_CYCLES        ((`READ_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define MAX_REPULSES       10
`define ADDR_BITS          17
`define ID_MAKER_SEL       1'b0
`define ID_DEVICE_SEL      1'b1
`endif

// File: logic/otp_prog_pkg.sv
package otp_prog_pkg;
    typedef enum {
        ST_IDLE, ST_PWR_MAIN, ST_PWR_PROG, ST_P1_SETUP, ST_P1_PULSE, ST_P1_HOLD,
        ST_V_READ, ST_V_SETUP, ST_V_PULSE, ST_V_HOLD, ST_LOWER_PROG, ST_LOWER_MAIN,
        ST_F_READ, ST_PWR_OFF, ST_ID_ENTER, ST_ID_READ, ST_DONE
    } prog_state_t;
    typedef logic [7:0] byte_t;
endpackage

// File: tb/otp_device_model.sv
module otp_device_model #(
    parameter int         PW     = 20,
    // Identification values are arbitrary
    parameter logic [7:0] MAKER  = 8'h5A,
    parameter logic [7:0] DEVICE = 8'hC3
) (
    input  wire logic                core_clk,
    input  wire logic                arst_n,
    input  wire logic [16:0]         memAddr,
    input  wire logic                chipEnable_n,
    input  wire logic                outputEnable_n,
    input  wire logic                program_strobe_low,
    input  wire otp_prog_pkg::byte_t dataOut,
    input  wire logic                dataOe,
    input  wire logic                mainSupplyHigh,
    input  wire logic                progSupplyHigh,
    input  wire logic                progSupplyOn,
    input  wire logic                identification_high_voltage,
    input  wire logic [1:0]          weakAddr,
    input  wire logic [7:0]          weakNeed,
    output otp_prog_pkg::byte_t      dataIn
);
    timeunit 1ns;
    timeprecision 100ps;
    import otp_prog_pkg::*;
    byte_t      mem [0:3];
    int         pulses [0:3];
    int         lowCnt;
    int         viol;
    byte_t      lastOut;
    logic       reading;
    logic [1:0] a;
    logic       marginal;
    assign a = memAddr[1:0];
    // A weak-need of zero marks a cell that verifies high but reads wrong at low supplies
    assign marginal = (weakNeed == 8'd0) && (a == weakAddr);
    assign reading = !chipEnable_n && !outputEnable_n;
    // Released pins show the inverse of the last value, so stale data never matches
    assign dataIn = !reading ? ~lastOut :
                    identification_high_voltage ? (memAddr[0] ? DEVICE : MAKER) :
                    mem[a] ^ {7'h00, marginal && !mainSupplyHigh};
    always @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            for (int i = 0; i < 4; i++) begin
                mem[i] <= 8'hFF;
                pulses[i] <= 0;
            end
            lowCnt <= 0;
            viol <= 0;
            lastOut <= 8'h00;
        end else begin
            if (reading) begin
                lastOut <= dataIn;
            end
            if (progSupplyHigh && !mainSupplyHigh) begin
                viol <= viol + 1;
            end
            if (reading && pulses[3] == 0 && !identification_high_voltage) begin
                viol <= viol + 1;
            end
            if (!program_strobe_low) begin
                lowCnt <= lowCnt + 1;
            end else if (lowCnt != 0) begin
                lowCnt <= 0;
                if (lowCnt * 100 < PW * 95 || lowCnt * 100 > PW * 105) begin
                    viol <= viol + 1;
                end
                if (!(mainSupplyHigh && progSupplyHigh && progSupplyOn)) begin
                    viol <= viol + 1;
                end
                if (chipEnable_n || !outputEnable_n || !dataOe) begin
                    viol <= viol + 1;
                end
                if (pulses[0] == 0 && memAddr != 17'h00000) begin
                    viol <= viol + 1;
                end
                pulses[a] <= pulses[a] + 1;
                // Bits only clear; a weak cell takes several pulses
                if (pulses[a] + 1 >= ((a == weakAddr) ? int'(weakNeed) : 1)) begin
                    mem[a] <= mem[a] & dataOut;
                end
            end
        end
    end
endmodule // otp_device_model

// File: tb/tb.sv
module tb;
    timeunit 1ns;
    timeprecision 100ps;
    import otp_prog_pkg::*;
    localparam int         PW        = 20;
    // Identification values are arbitrary
    localparam logic [7:0] MAKER_ID  = 8'h5A;
    localparam logic [7:0] DEVICE_ID = 8'hC3;
    logic core_clk, arst_n, startProgram, startIdRead, busy, done, passed, failed;
    logic [16:0] srcAddr, memAddr;
    byte_t srcData, makerCode, deviceCode, dataOut, dataIn;
    logic chipEnable_n, outputEnable_n, program_strobe_low, dataOe;
    logic mainSupplyHigh, progSupplyHigh, progSupplyOn, identification_high_voltage;
    logic [1:0] weakAddr;
    logic [7:0] weakNeed;
    int n_errors = 0;
    int total_checks = 0;
    assign srcData = 8'hA0 | {4'h0, srcAddr[3:0]};
    otp_programmer #(.PULSE_CYC(PW), .SETUP_CYC(3), .READ_CYC(2), .LAST_ADDR(17'h00003))
    u_otp_programmer (.core_clk(core_clk), .arst_n(arst_n), .startProgram(startProgram),
        .startIdRead(startIdRead), .srcAddr(srcAddr), .srcData(srcData), .busy(busy),
        .done(done), .passed(passed), .failed(failed), .makerCode(makerCode),
        .deviceCode(deviceCode), .memAddr(memAddr), .chipEnable_n(chipEnable_n),
        .outputEnable_n(outputEnable_n), .program_strobe_low(program_strobe_low),
        .dataOut(dataOut), .dataOe(dataOe), .dataIn(dataIn), .mainSupplyHigh(mainSupplyHigh),
        .progSupplyHigh(progSupplyHigh), .progSupplyOn(progSupplyOn),
        .identification_high_voltage(identification_high_voltage));
    otp_device_model #(.PW(PW), .MAKER(MAKER_ID), .DEVICE(DEVICE_ID))
    u_otp_device_model (.core_clk(core_clk), .arst_n(arst_n), .memAddr(memAddr),
        .chipEnable_n(chipEnable_n), .outputEnable_n(outputEnable_n),
        .program_strobe_low(program_strobe_low), .dataOut(dataOut), .dataOe(dataOe),
        .mainSupplyHigh(mainSupplyHigh), .progSupplyHigh(progSupplyHigh),
        .progSupplyOn(progSupplyOn), .identification_high_voltage(identification_high_voltage),
        .weakAddr(weakAddr), .weakNeed(weakNeed), .dataIn(dataIn));
    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end
    task automatic chk(input string name, input logic [31:0] expv, input logic [31:0] got);
        total_checks++;
        if (got !== expv) begin
            n_errors++;
            $display("[ERR] %s expected %0h seen %0h", name, expv, got);
        end
    endtask
    task automatic do_reset(input logic [1:0] wa, input logic [7:0] wn);
        @(posedge core_clk);
        #1;
        weakAddr = wa;
        weakNeed = wn;
        arst_n = 1'b0;
        repeat (5) @(posedge core_clk);
        #1;
        arst_n = 1'b1;
    endtask
    task automatic run_and_wait(input logic prog);
        int n;
        @(posedge core_clk);
        #1;
        startProgram = prog;
        startIdRead = !prog;
        @(posedge core_clk);
        #1;
        startProgram = 1'b0;
        startIdRead = 1'b0;
        chk("busy", 1, busy);
        chk("memAddr", 0, memAddr);
        n = 0;
        // Bounded wait keeps a stuck sequencer from hanging the run
        while (done !== 1'b1 && n < 20000) begin
            @(posedge core_clk);
            #1;
            n++;
        end
        chk("done", 1, done);
    endtask
    task automatic test_program_good;
        do_reset(2'd2, 8'd3);
        run_and_wait(1'b1);
        chk("passed", 1, passed);
        chk("failed", 0, failed);
        for (int i = 0; i < 4; i++) begin
            chk("pulses", (i == 2) ? 3 : 1, u_otp_device_model.pulses[i]);
            chk("cell", 8'hA0 | i, u_otp_device_model.mem[i]);
        end
        chk("supplies", 0, {mainSupplyHigh, progSupplyHigh, progSupplyOn});
        chk("violations", 0, u_otp_device_model.viol);
        $display("test_program_good finished");
    endtask
    task automatic test_program_fail;
        do_reset(2'd1, 8'd99);
        run_and_wait(1'b1);
        chk("failed", 1, failed);
        chk("passed", 0, passed);
        chk("pulses1", 11, u_otp_device_model.pulses[1]);
        chk("pulses2", 1, u_otp_device_model.pulses[2]);
        chk("supplies", 0, {mainSupplyHigh, progSupplyHigh});
        chk("violations", 0, u_otp_device_model.viol);
        $display("test_program_fail finished");
    endtask
    task automatic test_final_fail;
        // Cell 3 verifies at raised supplies but reads wrong at reduced ones
        do_reset(2'd3, 8'd0);
        run_and_wait(1'b1);
        chk("failed", 1, failed);
        chk("passed", 0, passed);
        chk("pulses3", 1, u_otp_device_model.pulses[3]);
        chk("violations", 0, u_otp_device_model.viol);
        $display("test_final_fail finished");
    endtask
    task automatic test_id_read;
        do_reset(2'd0, 8'd1);
        // Second read starts at once after the first completes
        repeat (2) begin
            run_and_wait(1'b0);
            chk("makerCode", MAKER_ID, makerCode);
            chk("deviceCode", DEVICE_ID, deviceCode);
        end
        chk("pulses0", 0, u_otp_device_model.pulses[0]);
        $display("test_id_read finished");
    endtask
    task automatic complete_run;
        $display("checks %0d mismatches %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    initial begin
        arst_n = 1'b0;
        startProgram = 1'b0;
        startIdRead = 1'b0;
        weakAddr = 2'd0;
        weakNeed = 8'd1;
        test_program_good();
        test_program_fail();
        test_final_fail();
        test_id_read();
        complete_run();
    end
    initial begin
        #400000;
        n_errors++;
        complete_run();
    end
endmodule // tb
